// *** core/sfmc_device.sv ***
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`include "sfmc_params.svh"
// Notes on behaviour
// - reset leaves standby, mode reads zero
// - transitions only on enabled sample clock ticks
// - mode 1 plus clock enters program
// - mode 2 moves program into normal
// - stop goes through program, then standby
// - clock cleared outside standby locks mode
// - registers accept host writes in every mode
// - 0x00ff clears interrupts, 0x80ff empties fifo
// - 128-byte fifo, per-slot format select
// - both slots only with equal averaging
// - one packet per output period
// - slot gives 2, 4, 8, 16 bytes
// - packet stored only if fully fits
// - slot a channels first, then slot b
// - byte order 15:8, 7:0, 31:24, 23:16
// - byte count in status upper byte
// - irq when write leaves words above threshold
// - mask bit 8 low enables fifo irq
// - fifo read drops irq two cycles later
// - fifo port reads pop bytes, free space
// - status bit 15 empties the fifo
// - host reads one word per access, any part of a packet
// - fifo reads advance up to two bytes, writes one packet
module sfmc_device (
   input wire logic clk,
   input wire logic rst_n,
   sfmc_if.dev bus,
   input wire sfmc_pkg::sfmc_chans_t sample_data,
   output logic [1:0] mode_code,
   output logic sample_take
);

   // -------------------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------------------
   function automatic logic wr_hit(input logic [6:0] a);
      wr_hit = bus.wr && (bus.addr == a);
   endfunction : wr_hit

   function automatic logic is32(input logic [2:0] f);
      is32 = (f == `SFMC_FMT_SUM32) || (f == `SFMC_FMT_FOUR32);
   endfunction : is32

   function automatic sfmc_pkg::sfmc_pkt_s pkt_build(input logic [2:0] fa,
                                                      input logic [2:0] fb,
                                                      input sfmc_pkg::sfmc_chans_t d);
      sfmc_pkg::sfmc_pkt_s p;
      logic [2:0] f;
      logic [31:0] v;
      logic [31:0] sum;
      p = '0;
      for (int s = 0; s < 2; s++) begin
         f = (s == 0) ? fa : fb;
         sum = d[4*s] + d[4*s+1] + d[4*s+2] + d[4*s+3];
         for (int c = 0; c < 4; c++) begin
            v = (f >= `SFMC_FMT_FOUR16) ? d[4*s+c] : sum;
            if (f != `SFMC_FMT_OFF && f <= `SFMC_FMT_FOUR32
                && (c == 0 || f >= `SFMC_FMT_FOUR16)) begin
               p.bytes[8*int'(p.size) +: 8] = v[15:8];
               p.bytes[8*int'(p.size) + 8 +: 8] = v[7:0];
               p.size = p.size + 6'd2;
               if (is32(f)) begin
                  p.bytes[8*int'(p.size) +: 8] = v[31:24];
                  p.bytes[8*int'(p.size) + 8 +: 8] = v[23:16];
                  p.size = p.size + 6'd2;
               end
            end
         end
      end
      pkt_build = p;
   endfunction : pkt_build

   // -------------------------------------------------------------------------
   // registers
   // -------------------------------------------------------------------------
   sfmc_pkg::sfmc_state_e state_r;
   logic [1:0] mode_cmd_r;
   logic clk_en_r;
   logic [5:0] clk_adj_r;
   logic [15:0] mask_r;
   logic [5:0] thr_r;
   logic [15:0] fmt_r;
   logic [15:0] avg_r;
   logic stuck_r;
   logic [11:0] div_r;
   logic [7:0] avg_cnt_r;
   logic [7:0] mem [0:127];
   logic [6:0] wptr_r;
   logic [6:0] rptr_r;
   logic [7:0] count_r;
   logic irq_flag_r;
   logic [15:0] rdata_r;
   logic rvalid_r;
   logic irq_r;

   // -------------------------------------------------------------------------
   // combinational
   // -------------------------------------------------------------------------
   logic tick;
   logic same_avg;
   logic [2:0] fmt_a;
   logic [2:0] fmt_b;
   logic [2:0] avg_sel;
   logic pkt_evt;
   sfmc_pkg::sfmc_pkt_s pkt;
   logic push_ok;
   logic pop_req;
   logic [1:0] pop_n;
   logic fifo_clr;
   logic [7:0] count_nxt;

   assign tick = clk_en_r && (div_r == 12'(`SFMC_SCLK_DIV - 1));
   assign same_avg = avg_r[2:0] == avg_r[`SFMC_AVG_B_LSB +: 3];
   assign fmt_a = fmt_r[2:0];
   assign fmt_b = same_avg ? fmt_r[`SFMC_FMT_B_LSB +: 3] : `SFMC_FMT_OFF;
   assign avg_sel = (fmt_a != `SFMC_FMT_OFF) ? avg_r[2:0] : avg_r[`SFMC_AVG_B_LSB +: 3];
   assign pkt_evt = tick && (state_r == sfmc_pkg::SFMC_ST_NORMAL)
                    && (avg_cnt_r == 8'((9'h1 << avg_sel) - 9'h1));
   assign pkt = pkt_build(fmt_a, fmt_b, sample_data);
   assign fifo_clr = wr_hit(`SFMC_REG_STATUS) && bus.wdata[`SFMC_STAT_FIFO_CLR];
   assign push_ok = pkt_evt && (pkt.size != 6'h0)
                    && ({2'h0, pkt.size} <= (`SFMC_FIFO_BYTES - count_r));
   assign pop_req = bus.rd && (bus.addr == `SFMC_REG_FIFO);
   assign pop_n = !pop_req ? 2'h0 : (count_r >= 8'h2) ? 2'h2 : count_r[1:0];
   assign count_nxt = count_r + (push_ok ? {2'h0, pkt.size} : 8'h0)
                      - {6'h0, pop_n};

   // -------------------------------------------------------------------------
   // configuration writes
   // -------------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_cmd_r <= `SFMC_MODE_STANDBY;
         clk_en_r <= 1'b0;
         clk_adj_r <= 6'h0;
         mask_r <= `SFMC_MASK_RST;
         thr_r <= 6'h0;
         fmt_r <= 16'h0;
         avg_r <= 16'h0;
      end else begin
         if (wr_hit(`SFMC_REG_MODE)) begin
            mode_cmd_r <= bus.wdata[1:0];
         end
         if (wr_hit(`SFMC_REG_SCLK)) begin
            clk_en_r <= bus.wdata[`SFMC_SCLK_EN];
            clk_adj_r <= bus.wdata[5:0];
         end
         if (wr_hit(`SFMC_REG_MASK)) begin
            mask_r <= bus.wdata;
         end
         if (wr_hit(`SFMC_REG_THRESH)) begin
            thr_r <= bus.wdata[`SFMC_THR_LSB +: 6];
         end
         if (wr_hit(`SFMC_REG_FORMAT)) begin
            fmt_r <= bus.wdata;
         end
         if (wr_hit(`SFMC_REG_AVG)) begin
            avg_r <= bus.wdata;
         end
      end
   end

   // -------------------------------------------------------------------------
   // sample clock, averaging counter, lock-up
   // -------------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_r <= 12'h0;
         avg_cnt_r <= 8'h0;
         stuck_r <= 1'b0;
      end else begin
         if (!clk_en_r || tick) begin
            div_r <= 12'h0;
         end else begin
            div_r <= div_r + 12'h1;
         end
         if (state_r != sfmc_pkg::SFMC_ST_NORMAL || pkt_evt) begin
            avg_cnt_r <= 8'h0;
         end else if (tick) begin
            avg_cnt_r <= avg_cnt_r + 8'h1;
         end
         if (wr_hit(`SFMC_REG_SCLK) && !bus.wdata[`SFMC_SCLK_EN]
             && state_r != sfmc_pkg::SFMC_ST_STANDBY) begin
            stuck_r <= 1'b1;
         end
      end
   end

   // -------------------------------------------------------------------------
   // mode state machine
   // -------------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= sfmc_pkg::SFMC_ST_STANDBY;
      end else if (tick && !stuck_r) begin
         case (state_r)
            sfmc_pkg::SFMC_ST_STANDBY: begin
               if (mode_cmd_r == `SFMC_MODE_PROGRAM) begin
                  state_r <= sfmc_pkg::SFMC_ST_PROGRAM;
               end
            end
            sfmc_pkg::SFMC_ST_PROGRAM: begin
               if (mode_cmd_r == `SFMC_MODE_NORMAL) begin
                  state_r <= sfmc_pkg::SFMC_ST_NORMAL;
               end else if (mode_cmd_r == `SFMC_MODE_STANDBY) begin
                  state_r <= sfmc_pkg::SFMC_ST_STANDBY;
               end
            end
            sfmc_pkg::SFMC_ST_NORMAL: begin
               if (mode_cmd_r != `SFMC_MODE_NORMAL) begin
                  state_r <= sfmc_pkg::SFMC_ST_PROGRAM;
               end
            end
            default: begin
               state_r <= sfmc_pkg::SFMC_ST_STANDBY;
            end
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // fifo storage and pointers
   // -------------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (push_ok) begin
         for (int i = 0; i < `SFMC_PKT_MAX; i++) begin
            if (i < int'(pkt.size)) begin
               mem[wptr_r + 7'(i)] <= pkt.bytes[8*i +: 8];
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wptr_r <= 7'h0;
         rptr_r <= 7'h0;
         count_r <= 8'h0;
      end else if (fifo_clr) begin
         wptr_r <= 7'h0;
         rptr_r <= 7'h0;
         count_r <= 8'h0;
      end else begin
         if (push_ok) begin
            wptr_r <= wptr_r + {1'b0, pkt.size};
         end
         rptr_r <= rptr_r + {5'h0, pop_n};
         count_r <= count_nxt;
      end
   end

   // -------------------------------------------------------------------------
   // fifo threshold interrupt; a set beats a clear in the same cycle
   // -------------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_flag_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         if (push_ok && !fifo_clr && (count_nxt[7:1] > {1'b0, thr_r})) begin
            irq_flag_r <= 1'b1;
         end else if (pop_n != 2'h0
                      || (wr_hit(`SFMC_REG_STATUS) && bus.wdata[`SFMC_STAT_IRQ])) begin
            irq_flag_r <= 1'b0;
         end
         irq_r <= irq_flag_r && !mask_r[`SFMC_MASK_FIFO];
      end
   end

   // -------------------------------------------------------------------------
   // read path, data one cycle after the strobe
   // -------------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= 16'h0;
         rvalid_r <= 1'b0;
         mode_code <= `SFMC_MODE_STANDBY;
         sample_take <= 1'b0;
      end else begin
         rvalid_r <= bus.rd;
         sample_take <= push_ok;
         case (state_r)
            sfmc_pkg::SFMC_ST_PROGRAM: mode_code <= `SFMC_MODE_PROGRAM;
            sfmc_pkg::SFMC_ST_NORMAL: mode_code <= `SFMC_MODE_NORMAL;
            default: mode_code <= `SFMC_MODE_STANDBY;
         endcase
         if (bus.rd) begin
            case (bus.addr)
               `SFMC_REG_STATUS: rdata_r <= {count_r, 7'h0, irq_flag_r};
               `SFMC_REG_MASK: rdata_r <= mask_r;
               `SFMC_REG_THRESH: rdata_r <= {2'h0, thr_r, 8'h0};
               `SFMC_REG_MODE: rdata_r <= {14'h0, mode_code};
               `SFMC_REG_FORMAT: rdata_r <= fmt_r;
               `SFMC_REG_AVG: rdata_r <= avg_r;
               `SFMC_REG_SCLK: rdata_r <= {8'h0, clk_en_r, 1'b0, clk_adj_r};
               `SFMC_REG_FIFO: begin
                  rdata_r <= {(pop_n != 2'h0) ? mem[rptr_r] : 8'h0,
                              (pop_n == 2'h2) ? mem[rptr_r + 7'h1] : 8'h0};
               end
               default: rdata_r <= 16'h0;
            endcase
         end
      end
   end

   assign bus.rdata = rdata_r;
   assign bus.rvalid = rvalid_r;
   assign bus.fifo_irq = irq_r;

endmodule : sfmc_device

// *** shared/sfmc_params.svh ***
`ifndef SFMC_PARAMS_SVH
`define SFMC_PARAMS_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define SFMC_REG_STATUS 7'h00
`define SFMC_REG_MASK 7'h01
`define SFMC_REG_THRESH 7'h06
`define SFMC_REG_MODE 7'h10
`define SFMC_REG_FORMAT 7'h11
`define SFMC_REG_AVG 7'h12
`define SFMC_REG_SCLK 7'h4b
`define SFMC_REG_FIFO 7'h60

// ----------------------------------------------------------------------------
// field positions and values
// ----------------------------------------------------------------------------
`define SFMC_STAT_FIFO_CLR 15
`define SFMC_STAT_IRQ 0
`define SFMC_MASK_FIFO 8
`define SFMC_THR_LSB 8
`define SFMC_SCLK_EN 7
`define SFMC_FMT_B_LSB 4
`define SFMC_AVG_B_LSB 4
`define SFMC_MODE_STANDBY 2'h0
`define SFMC_MODE_PROGRAM 2'h1
`define SFMC_MODE_NORMAL 2'h2
`define SFMC_FMT_OFF 3'h0
`define SFMC_FMT_SUM16 3'h1
`define SFMC_FMT_SUM32 3'h2
`define SFMC_FMT_FOUR16 3'h3
`define SFMC_FMT_FOUR32 3'h4

// ----------------------------------------------------------------------------
// reset values and sizes
// ----------------------------------------------------------------------------
`define SFMC_MASK_RST 16'hffff
`define SFMC_FIFO_BYTES 8'h80
`define SFMC_PKT_MAX 32

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define SFMC_CLK_HZ 100000000
`define SFMC_SCLK_HZ 32000
`define SFMC_SCLK_DIV (`SFMC_CLK_HZ / `SFMC_SCLK_HZ)

`endif

// *** shared/sfmc_pkg.sv ***
package sfmc_pkg;
   typedef enum logic [1:0] {
      SFMC_ST_STANDBY = 2'h0,
      SFMC_ST_PROGRAM = 2'h1,
      SFMC_ST_NORMAL = 2'h3
   } sfmc_state_e;

   typedef enum logic [1:0] {
      SFMC_H_IDLE = 2'h0,
      SFMC_H_ISSUE = 2'h1,
      SFMC_H_WAIT = 2'h3
   } sfmc_hstate_e;

   // eight channels: slot a ch1..4 then slot b ch1..4
   typedef logic [7:0][31:0] sfmc_chans_t;

   typedef struct packed {
      logic [255:0] bytes;
      logic [5:0] size;
   } sfmc_pkt_s;
endpackage : sfmc_pkg

// *** shared/sfmc_if.sv ***
`timescale 1ns/1ps
interface sfmc_if;
   logic [6:0] addr;
   logic [15:0] wdata;
   logic wr;
   logic rd;
   logic [15:0] rdata;
   logic rvalid;
   logic fifo_irq;
   modport host (output addr, output wdata, output wr, output rd,
                 input rdata, input rvalid, input fifo_irq);
   modport dev (input addr, input wdata, input wr, input rd,
                output rdata, output rvalid, output fifo_irq);
endinterface : sfmc_if

// *** core/sfmc_host.sv ***
`timescale 1ns/1ps
`include "sfmc_params.svh"
module sfmc_host (
   input wire logic clk,
   input wire logic rst_n,
   sfmc_if.host bus,
   input wire logic [2:0] sw_addr,
   input wire logic [15:0] sw_wdata,
   input wire logic sw_wr,
   input wire logic sw_rd,
   output logic [15:0] sw_rdata
);

   // -------------------------------------------------------------------------
   // controller registers: 0 target, 1 wdata, 2 command, 3 status, 4 rdata
   // -------------------------------------------------------------------------
   sfmc_pkg::sfmc_hstate_e state_r;
   logic [6:0] tgt_r;
   logic [15:0] wd_r;
   logic [15:0] rd_data_r;
   logic is_read_r;
   logic stop_r;
   logic [1:0] step_r;
   logic [6:0] addr_r;
   logic [15:0] wdata_r;
   logic wr_r;
   logic rd_r;
   logic busy;
   logic go;

   assign busy = state_r != sfmc_pkg::SFMC_H_IDLE;
   assign go = sw_wr && sw_addr == 3'h2 && !busy && (sw_wdata[2:0] != 3'h0);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tgt_r <= 7'h0;
         wd_r <= 16'h0;
         sw_rdata <= 16'h0;
      end else begin
         if (sw_wr && sw_addr == 3'h0) begin
            tgt_r <= sw_wdata[6:0];
         end
         if (sw_wr && sw_addr == 3'h1) begin
            wd_r <= sw_wdata;
         end
         if (sw_rd) begin
            case (sw_addr)
               3'h0: sw_rdata <= {9'h0, tgt_r};
               3'h1: sw_rdata <= wd_r;
               3'h3: sw_rdata <= {14'h0, bus.fifo_irq, busy};
               3'h4: sw_rdata <= rd_data_r;
               default: sw_rdata <= 16'h0;
            endcase
         end
      end
   end

   // -------------------------------------------------------------------------
   // transfer sequencer; stop walks program, fifo clear, standby
   // -------------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= sfmc_pkg::SFMC_H_IDLE;
         is_read_r <= 1'b0;
         stop_r <= 1'b0;
         step_r <= 2'h0;
         addr_r <= 7'h0;
         wdata_r <= 16'h0;
         wr_r <= 1'b0;
         rd_r <= 1'b0;
         rd_data_r <= 16'h0;
      end else begin
         wr_r <= 1'b0;
         rd_r <= 1'b0;
         case (state_r)
            sfmc_pkg::SFMC_H_IDLE: begin
               if (go) begin
                  state_r <= sfmc_pkg::SFMC_H_ISSUE;
                  stop_r <= sw_wdata[2];
                  is_read_r <= !sw_wdata[2] && sw_wdata[1];
                  step_r <= 2'h0;
                  addr_r <= sw_wdata[2] ? `SFMC_REG_MODE : tgt_r;
                  wdata_r <= sw_wdata[2] ? 16'h0001 : wd_r;
                  wr_r <= sw_wdata[2] || sw_wdata[0];
                  rd_r <= !sw_wdata[2] && !sw_wdata[0];
               end
            end
            sfmc_pkg::SFMC_H_ISSUE: begin
               if (is_read_r) begin
                  state_r <= sfmc_pkg::SFMC_H_WAIT;
               end else if (stop_r && step_r == 2'h0) begin
                  step_r <= 2'h1;
                  addr_r <= `SFMC_REG_STATUS;
                  wdata_r <= 16'h80ff;
                  wr_r <= 1'b1;
               end else if (stop_r && step_r == 2'h1) begin
                  step_r <= 2'h2;
                  addr_r <= `SFMC_REG_MODE;
                  wdata_r <= 16'h0000;
                  wr_r <= 1'b1;
               end else begin
                  state_r <= sfmc_pkg::SFMC_H_IDLE;
               end
            end
            sfmc_pkg::SFMC_H_WAIT: begin
               if (bus.rvalid) begin
                  rd_data_r <= bus.rdata;
                  state_r <= sfmc_pkg::SFMC_H_IDLE;
               end
            end
            default: begin
               state_r <= sfmc_pkg::SFMC_H_IDLE;
            end
         endcase
      end
   end

   assign bus.addr = addr_r;
   assign bus.wdata = wdata_r;
   assign bus.wr = wr_r;
   assign bus.rd = rd_r;

endmodule : sfmc_host

// *** bench/sfmc_monitor.sv ***
`timescale 1ns/1ps
`include "sfmc_params.svh"
module sfmc_monitor (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [6:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [15:0] rdata,
   input wire logic rvalid,
   input wire logic fifo_irq
);
   // ---------------------------------------------------------------------
   // shadow of the mask register
   // ---------------------------------------------------------------------
   logic [15:0] mask_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mask_r <= `SFMC_MASK_RST;
      end else if (wr && addr == `SFMC_REG_MASK) begin
         mask_r <= wdata;
      end
   end

   // ---------------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------------
   default clocking mon_cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   AST_RVALID_ON_RD: assert property (rd |=> rvalid)
      else $error("rvalid missing after read");
   AST_RVALID_ONLY_RD: assert property (!rd |=> !rvalid)
      else $error("rvalid without read");
   AST_NO_WR_RD: assert property (!(wr && rd))
      else $error("write and read together");
   AST_IRQ_MASKED: assert property (fifo_irq |-> !$past(mask_r[`SFMC_MASK_FIFO]))
      else $error("fifo irq while masked");
   AST_IRQ_DROP_ON_POP: assert property (rd && addr == `SFMC_REG_FIFO |-> ##[1:2] !fifo_irq)
      else $error("fifo irq held after pop");
   AST_IRQ_CLEAR_STATUS: assert property
      (wr && addr == `SFMC_REG_STATUS && wdata[0] |-> ##[1:2] !fifo_irq)
      else $error("fifo irq held after clear");
   AST_STATUS_FORM: assert property
      (rd && addr == `SFMC_REG_STATUS |=> rdata[15:8] <= 8'h80 && rdata[7:1] == 7'h00)
      else $error("status read malformed");
   AST_IRQ_IN_STATUS: assert property (rd && addr == `SFMC_REG_STATUS && fifo_irq
      && !$past(wr) && !$past(rd) |=> rdata[0])
      else $error("irq pin high but status flag low");
   AST_MODE_CODE_READ: assert property
      (rd && addr == `SFMC_REG_MODE |=> rdata[15:2] == 14'h0 && rdata[1:0] != 2'h3)
      else $error("mode read out of range");
endmodule : sfmc_monitor

// *** bench/sfmc_tb.sv ***
`timescale 1ns/1ps
`include "sfmc_params.svh"
module sfmc_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [2:0] sw_addr = 3'h0;
   logic [15:0] sw_wdata = 16'h0000;
   logic sw_wr = 1'b0;
   logic sw_rd = 1'b0;
   logic [15:0] sw_rdata;
   sfmc_pkg::sfmc_chans_t sample_data;
   logic [1:0] mode_code;
   logic sample_take;
   logic [15:0] d;
   int takes = 0;
   int t0;
   int err_total = 0;
   int check_count = 0;

   always #5 clk = ~clk;
   always @(posedge clk) if (sample_take === 1'b1) takes <= takes + 1;

   sfmc_if sfmc_if_inst ();
   sfmc_device sfmc_device_inst (.clk(clk), .rst_n(rst_n), .bus(sfmc_if_inst),
      .sample_data(sample_data), .mode_code(mode_code), .sample_take(sample_take));
   sfmc_host sfmc_host_inst (.clk(clk), .rst_n(rst_n), .bus(sfmc_if_inst), .sw_addr(sw_addr),
      .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
   sfmc_monitor sfmc_monitor_inst (.clk(clk), .rst_n(rst_n), .addr(sfmc_if_inst.addr),
      .wdata(sfmc_if_inst.wdata), .wr(sfmc_if_inst.wr), .rd(sfmc_if_inst.rd),
      .rdata(sfmc_if_inst.rdata), .rvalid(sfmc_if_inst.rvalid),
      .fifo_irq(sfmc_if_inst.fifo_irq));

   // ---------------------------------------------------------------------
   // access tasks
   // ---------------------------------------------------------------------
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         $display("ERROR %s expected %h seen %h", name, exp, seen);
         err_total++;
      end
   endtask : check

   task automatic sw_wr_t(input logic [2:0] a, input logic [15:0] v);
      @(posedge clk);
      sw_addr <= a;
      sw_wdata <= v;
      sw_wr <= 1'b1;
      @(posedge clk);
      sw_wr <= 1'b0;
   endtask : sw_wr_t

   task automatic sw_rd_t(input logic [2:0] a, output logic [15:0] v);
      @(posedge clk);
      sw_addr <= a;
      sw_rd <= 1'b1;
      @(posedge clk);
      sw_rd <= 1'b0;
      #1;
      v = sw_rdata;
   endtask : sw_rd_t

   task automatic wait_idle;
      logic [15:0] s;
      s = 16'h0001;
      for (int i = 0; i < 100 && s[0] !== 1'b0; i++) sw_rd_t(3'h3, s);
      check("host busy", {15'h0, s[0]}, 16'h0000);
   endtask : wait_idle

   task automatic dev_wr(input logic [6:0] a, input logic [15:0] v);
      sw_wr_t(3'h0, {9'h0, a});
      sw_wr_t(3'h1, v);
      sw_wr_t(3'h2, 16'h0001);
      wait_idle();
   endtask : dev_wr

   task automatic dev_rd(input logic [6:0] a, output logic [15:0] v);
      sw_wr_t(3'h0, {9'h0, a});
      sw_wr_t(3'h2, 16'h0002);
      wait_idle();
      sw_rd_t(3'h4, v);
   endtask : dev_rd

   task automatic wait_mode(input logic [1:0] m);
      for (int i = 0; i < 8000 && mode_code !== m; i++) begin
         @(posedge clk);
         #1;
      end
      check("mode_code", {14'h0, mode_code}, {14'h0, m});
   endtask : wait_mode

   task automatic wait_take(input int n);
      int target;
      target = takes + n;
      for (int g = 0; g < 4000 * n && takes < target; g++) @(posedge clk);
      #1;
      check("packets", takes[15:0], target[15:0]);
   endtask : wait_take

   // one packet: slot a then slot b, each 32-bit value as low half then high half
   task automatic read_words(input int first, input int last);
      logic [31:0] s;
      logic [15:0] v;
      for (int j = first; j <= last; j++) begin
         s = sample_data[j / 2];
         dev_rd(`SFMC_REG_FIFO, v);
         check("fifo word", v, j[0] ? s[31:16] : s[15:0]);
      end
   endtask : read_words

   task automatic complete_run;
      if (err_total == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : complete_run

   // ---------------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------------
   initial begin
      repeat (95000) @(posedge clk);
      err_total++;
      complete_run();
   end

   initial begin
      for (int i = 0; i < 8; i++) sample_data[i] = 32'h10203040 + 32'h01010101 * i;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      dev_rd(`SFMC_REG_MODE, d);
      check("mode reset", d, 16'h0000);
      dev_rd(`SFMC_REG_MASK, d);
      check("mask reset", d, `SFMC_MASK_RST);
      dev_rd(7'h7f, d);
      check("unmapped", d, 16'h0000);
      dev_wr(`SFMC_REG_MODE, 16'h0001);
      repeat (4000) @(posedge clk);
      #1;
      check("mode no clock", {14'h0, mode_code}, 16'h0000);
      dev_wr(`SFMC_REG_SCLK, 16'h0080);
      wait_mode(`SFMC_MODE_PROGRAM);
      dev_wr(`SFMC_REG_FORMAT, 16'h0044);
      dev_wr(`SFMC_REG_AVG, 16'h0000);
      dev_wr(`SFMC_REG_THRESH, 16'h0f00);
      dev_wr(`SFMC_REG_MODE, 16'h0002);
      wait_mode(`SFMC_MODE_NORMAL);
      wait_take(1);
      dev_rd(`SFMC_REG_STATUS, d);
      check("status first", d, 16'h2001);
      check("irq masked", {15'h0, sfmc_if_inst.fifo_irq}, 16'h0000);
      dev_wr(`SFMC_REG_MASK, 16'hfeff);
      repeat (2) @(posedge clk);
      #1;
      check("irq unmasked", {15'h0, sfmc_if_inst.fifo_irq}, 16'h0001);
      sw_rd_t(3'h3, d);
      check("host irq", d, 16'h0002);
      read_words(0, 0);
      check("irq after pop", {15'h0, sfmc_if_inst.fifo_irq}, 16'h0000);
      dev_rd(`SFMC_REG_STATUS, d);
      check("status pop", d, 16'h1e00);
      read_words(1, 15);
      wait_take(4);
      dev_rd(`SFMC_REG_STATUS, d);
      check("status full", d, 16'h8001);
      dev_wr(`SFMC_REG_STATUS, 16'h00ff);
      dev_rd(`SFMC_REG_STATUS, d);
      check("status irq clr", d, 16'h8000);
      t0 = takes;
      repeat (3500) @(posedge clk);
      check("drop full", takes[15:0], t0[15:0]);
      read_words(0, 7);
      t0 = takes;
      repeat (3500) @(posedge clk);
      check("drop short", takes[15:0], t0[15:0]);
      dev_rd(`SFMC_REG_STATUS, d);
      check("status short", d, 16'h7000);
      read_words(8, 15);
      wait_take(1);
      dev_rd(`SFMC_REG_STATUS, d);
      check("status resume", d, 16'h8001);
      dev_wr(`SFMC_REG_MODE, 16'h0001);
      wait_mode(`SFMC_MODE_PROGRAM);
      dev_wr(`SFMC_REG_STATUS, 16'h80ff);
      dev_rd(`SFMC_REG_STATUS, d);
      check("status flushed", d, 16'h0000);
      dev_wr(`SFMC_REG_MODE, 16'h0000);
      wait_mode(`SFMC_MODE_STANDBY);
      dev_wr(`SFMC_REG_MODE, 16'h0001);
      wait_mode(`SFMC_MODE_PROGRAM);
      dev_wr(`SFMC_REG_SCLK, 16'h0000);
      dev_wr(`SFMC_REG_MODE, 16'h0000);
      dev_wr(`SFMC_REG_SCLK, 16'h0080);
      repeat (7000) @(posedge clk);
      #1;
      check("mode locked", {14'h0, mode_code}, 16'h0001);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      check("mode after reset", {14'h0, mode_code}, 16'h0000);
      dev_wr(`SFMC_REG_SCLK, 16'h0080);
      dev_wr(`SFMC_REG_MODE, 16'h0001);
      wait_mode(`SFMC_MODE_PROGRAM);
      dev_wr(`SFMC_REG_FORMAT, 16'h0012);
      dev_wr(`SFMC_REG_AVG, 16'h0010);
      dev_wr(`SFMC_REG_MODE, 16'h0002);
      wait_mode(`SFMC_MODE_NORMAL);
      wait_take(1);
      dev_rd(`SFMC_REG_STATUS, d);
      check("status sum", d, 16'h0401);
      t0 = sample_data[0] + sample_data[1] + sample_data[2] + sample_data[3];
      dev_rd(`SFMC_REG_FIFO, d);
      check("sum low", d, t0[15:0]);
      dev_rd(`SFMC_REG_FIFO, d);
      check("sum high", d, t0[31:16]);
      sw_wr_t(3'h2, 16'h0004);
      wait_idle();
      wait_mode(`SFMC_MODE_STANDBY);
      complete_run();
   end
endmodule : sfmc_tb
